// ### wae_defs.svh
`ifndef WAE_DEFS_SVH
`define WAE_DEFS_SVH
// ======================================================================
// Register byte offsets
`define WAE_REG_CMD      5'h00
`define WAE_REG_CTRL     5'h04
`define WAE_REG_STAT     5'h08
`define WAE_REG_CNT      5'h0c
// ======================================================================
// Command bits (write one to press the key)
`define WAE_CMD_CAVG     0
`define WAE_CMD_CENV     1
`define WAE_CMD_NAVG     2
`define WAE_CMD_NENV     3
`define WAE_CMD_FRZ      4
`define WAE_CMD_SNGL     5
`define WAE_CMD_PASS     6
`define WAE_CMD_OTHER    7
// ======================================================================
// Control bits and reset values
`define WAE_CTRL_HOLD    0
`define WAE_NIDX_RST     3'h0
`define WAE_NIDX_MAX     3'h5
`define WAE_N_MIN        9'h008
// ======================================================================
// Bus responses
`define WAE_RESP_OKAY    2'h0
`define WAE_RESP_SLVERR  2'h2
// ======================================================================
// Pass-count auto-step period while the key is held
`define WAE_STEP_MS      500
`define WAE_CLK_KHZ      50000
`endif

// ### wae_pkg.sv
package wae_pkg;
    // Gray along normal -> average -> counted -> frozen -> envelope
    typedef enum logic [2:0] {
        WAE_NORMAL = 3'h0,
        WAE_CAVG   = 3'h1,
        WAE_NAVG   = 3'h3,
        WAE_FROZEN = 3'h2,
        WAE_CENV   = 3'h6,
        WAE_NENV   = 3'h7,
        WAE_SINGLE = 3'h5
    } wae_mode_t;
endpackage

// ### wae_ctrl.sv
// Contract
// - Continuous average counts acquisitions up to pass count, then flags overflow.
// - Continuous average key cancels freeze, envelopes, pass prompt and counted average.
// - Freeze during continuous average stops it, showing total limited to pass count.
// - Single freeze in continuous average adds one acquisition, then freezes.
// - Second continuous average press returns to normal digitizing.
// - Other processing keys during continuous average start the new function.
// - Continuous envelope key cancels all other modes and starts enveloping.
// - Continuous envelope keeps and shows a running merged total.
// - Freeze during continuous envelope stops it and shows the total.
// - Single freeze in continuous envelope merges one more, then freezes.
// - Other processing keys during continuous envelope start the new function.
// - Second continuous envelope press turns it off, back to normal.
// - Pass-count key raises a blinking prompt showing the current pass count; here pass_prompt is a steady level.
// - Holding the pass-count key steps 8 to 256 cyclically, keeping the last.
// - Any next key removes the pass-count prompt.
// - Counted average counts down from pass count, freezes at zero, shows count.
// - Counted average is cancelled by freeze or other processing keys.
// - Counted envelope counts down to zero, freezes, shows pass count.
// - Counted envelope is cancelled by freeze or other processing keys.
// - Modes work at every timebase setting.
// - Single freeze takes one complete triggered record then freezes.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "wae_defs.svh"

module wae_ctrl #(
    parameter int unsigned STEP_CYC = `WAE_STEP_MS * `WAE_CLK_KHZ,
    parameter int unsigned ADDR_W   = 5
) (
    // Clock, reset, enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Acquisition side
    input  wire logic              acq_done,
    output logic                   avg_en,
    output logic                   envelope_en,
    output logic                   acq_arm,
    output logic                   frozen,
    // Readout side
    output logic [15:0]            readout,
    output logic                   over_flag,
    output logic                   pass_prompt
);
    localparam int unsigned SW = $clog2(STEP_CYC + 1);

    // ==================================================================
    // Bus slave
    logic                  awready_q;
    logic                  wready_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  aw_full_q;
    logic                  w_full_q;
    logic [ADDR_W-1:0]     waddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  arready_q;
    logic                  rvalid_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;
    logic                  wr_fire;
    logic                  waddr_ok;

    assign wr_fire  = aw_full_q && w_full_q && !bvalid_q;
    assign waddr_ok = (waddr_q[ADDR_W-1:2] <= 3'h3);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b0;
            waddr_q   <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_full_q <= 1'b1;
                waddr_q   <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end else if (!aw_full_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_full_q <= 1'b0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end else if (!w_full_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `WAE_RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= waddr_ok ? `WAE_RESP_OKAY : `WAE_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Key decode, one key wins per write
    logic [7:0] key;
    logic       k_frz;
    logic       k_sng;
    logic       k_cavg;
    logic       k_cenv;
    logic       k_navg;
    logic       k_nenv;
    logic       k_any;

    assign key    = (wr_fire && waddr_q == `WAE_REG_CMD && wstrb_q[0]) ? wdata_q[7:0] : 8'h0;
    assign k_frz  = key[`WAE_CMD_FRZ];
    assign k_sng  = key[`WAE_CMD_SNGL] && !k_frz;
    assign k_cavg = key[`WAE_CMD_CAVG] && !key[`WAE_CMD_FRZ] && !key[`WAE_CMD_SNGL];
    assign k_cenv = key[`WAE_CMD_CENV] && !k_cavg && !key[`WAE_CMD_FRZ] && !key[`WAE_CMD_SNGL];
    assign k_navg = key[`WAE_CMD_NAVG] && key[1:0] == 2'h0 && key[5:4] == 2'h0;
    assign k_nenv = key[`WAE_CMD_NENV] && key[2:0] == 3'h0 && key[5:4] == 2'h0;
    assign k_any  = |key;

    // ==================================================================
    // Control register and pass-count selection
    logic            hold_q;
    logic            prompt_q;
    logic [2:0]      nidx_q;
    logic [SW-1:0]   step_q;
    logic [8:0]      n_w;
    logic [15:0]     n16;

    assign n_w = `WAE_N_MIN << nidx_q;
    assign n16 = {7'h0, n_w};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= 1'b0;
        end else if (ce && wr_fire && waddr_q == `WAE_REG_CTRL && wstrb_q[0]) begin
            hold_q <= wdata_q[`WAE_CTRL_HOLD];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prompt_q <= 1'b0;
        end else if (ce) begin
            if (key[`WAE_CMD_PASS]) begin
                prompt_q <= 1'b1;
            end else if (k_any) begin
                prompt_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nidx_q <= `WAE_NIDX_RST;
            step_q <= '0;
        end else if (ce) begin
            if (!(hold_q && prompt_q)) begin
                step_q <= '0;
            end else if (step_q == SW'(STEP_CYC - 1)) begin
                step_q <= '0;
                nidx_q <= (nidx_q == `WAE_NIDX_MAX) ? 3'h0 : nidx_q + 3'h1;
            end else begin
                step_q <= step_q + SW'(1);
            end
        end
    end

    // ==================================================================
    // Mode sequencer and acquisition count
    wae_pkg::wae_mode_t mode_q;
    logic [15:0]        cnt_q;
    logic               over_q;
    logic [1:0]         sproc_q;
    logic               acq_w;

    // Timebase is not looked at: every setting processes alike
    assign acq_w = acq_done && !k_any;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= wae_pkg::WAE_NORMAL;
            cnt_q   <= 16'h0;
            over_q  <= 1'b0;
            sproc_q <= 2'h0;
        end else if (ce) begin
            if (k_frz) begin
                mode_q <= wae_pkg::WAE_FROZEN;
            end else if (k_sng) begin
                mode_q  <= wae_pkg::WAE_SINGLE;
                sproc_q <= {mode_q == wae_pkg::WAE_CENV, mode_q == wae_pkg::WAE_CAVG};
            end else if (k_cavg) begin
                mode_q <= (mode_q == wae_pkg::WAE_CAVG) ? wae_pkg::WAE_NORMAL
                                                        : wae_pkg::WAE_CAVG;
                cnt_q  <= 16'h0;
                over_q <= 1'b0;
            end else if (k_cenv) begin
                mode_q <= (mode_q == wae_pkg::WAE_CENV) ? wae_pkg::WAE_NORMAL
                                                        : wae_pkg::WAE_CENV;
                cnt_q  <= 16'h0;
                over_q <= 1'b0;
            end else if (k_navg) begin
                mode_q <= wae_pkg::WAE_NAVG;
                cnt_q  <= n16;
                over_q <= 1'b0;
            end else if (k_nenv) begin
                mode_q <= wae_pkg::WAE_NENV;
                cnt_q  <= n16;
                over_q <= 1'b0;
            end else if (acq_w) begin
                unique case (mode_q)
                    wae_pkg::WAE_CAVG: begin
                        if (cnt_q < n16) begin
                            cnt_q <= cnt_q + 16'h1;
                        end else begin
                            over_q <= 1'b1;
                        end
                    end
                    wae_pkg::WAE_CENV: begin
                        if (cnt_q != 16'hffff) begin
                            cnt_q <= cnt_q + 16'h1;
                        end
                    end
                    wae_pkg::WAE_NAVG, wae_pkg::WAE_NENV: begin
                        if (cnt_q <= 16'h1) begin
                            mode_q <= wae_pkg::WAE_FROZEN;
                            cnt_q  <= n16;
                        end else begin
                            cnt_q <= cnt_q - 16'h1;
                        end
                    end
                    wae_pkg::WAE_SINGLE: begin
                        mode_q <= wae_pkg::WAE_FROZEN;
                        if (sproc_q[0] && cnt_q < n16) begin
                            cnt_q <= cnt_q + 16'h1;
                        end else if (sproc_q[1] && cnt_q != 16'hffff) begin
                            cnt_q <= cnt_q + 16'h1;
                        end
                    end
                    wae_pkg::WAE_NORMAL, wae_pkg::WAE_FROZEN: begin
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // Registered outputs toward acquisition and readout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            avg_en      <= 1'b0;
            envelope_en <= 1'b0;
            acq_arm     <= 1'b0;
            frozen      <= 1'b0;
        end else if (ce) begin
            avg_en      <= mode_q == wae_pkg::WAE_CAVG || mode_q == wae_pkg::WAE_NAVG ||
                           (mode_q == wae_pkg::WAE_SINGLE && sproc_q[0]);
            envelope_en <= mode_q == wae_pkg::WAE_CENV || mode_q == wae_pkg::WAE_NENV ||
                           (mode_q == wae_pkg::WAE_SINGLE && sproc_q[1]);
            acq_arm     <= mode_q != wae_pkg::WAE_FROZEN;
            frozen      <= mode_q == wae_pkg::WAE_FROZEN;
        end
    end

    // ==================================================================
    // Read channel
    logic [31:0] rd_w;
    logic        rd_ok;

    always_comb begin
        rd_w  = 32'h0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[ADDR_W-1:2])
            3'h0: rd_w = 32'h0;
            3'h1: rd_w = {31'h0, hold_q};
            3'h2: rd_w = {14'h0, n_w, 1'b0, nidx_q, prompt_q, over_q, mode_q};
            3'h3: rd_w = {16'h0, cnt_q};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= `WAE_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_w;
                rresp_q   <= rd_ok ? `WAE_RESP_OKAY : `WAE_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign readout       = cnt_q;
    assign over_flag     = over_q;
    assign pass_prompt   = prompt_q;

    // ==================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CAVG_ON: assert property (
        ce && k_cavg && mode_q != wae_pkg::WAE_CAVG |=> mode_q == wae_pkg::WAE_CAVG && cnt_q == 16'h0)
        else $error("continuous average did not start");
    AST_CAVG_OFF: assert property (
        ce && k_cavg && mode_q == wae_pkg::WAE_CAVG |=> mode_q == wae_pkg::WAE_NORMAL)
        else $error("second average press did not end averaging");
    AST_CENV_OFF: assert property (
        ce && k_cenv && mode_q == wae_pkg::WAE_CENV ##1 ce |=> !envelope_en)
        else $error("second envelope press left envelope on");
    AST_CAVG_CNT: assert property (
        ce && acq_w && mode_q == wae_pkg::WAE_CAVG && cnt_q < n16
        |=> cnt_q == $past(cnt_q) + 16'h1)
        else $error("average count did not advance");
    AST_CAVG_OVER: assert property (
        ce && acq_w && mode_q == wae_pkg::WAE_CAVG && cnt_q == n16
        |=> over_q && cnt_q == $past(cnt_q))
        else $error("average count passed pass count");
    AST_FREEZE: assert property (
        ce && k_frz |=> mode_q == wae_pkg::WAE_FROZEN && cnt_q == $past(cnt_q))
        else $error("freeze did not stop processing");
    AST_SINGLE: assert property (
        ce && acq_w && mode_q == wae_pkg::WAE_SINGLE |=> mode_q == wae_pkg::WAE_FROZEN)
        else $error("single capture did not freeze");
    AST_COUNTED_END: assert property (
        ce && acq_w && (mode_q == wae_pkg::WAE_NAVG || mode_q == wae_pkg::WAE_NENV)
        && cnt_q == 16'h1 |=> mode_q == wae_pkg::WAE_FROZEN && cnt_q == n16)
        else $error("counted mode did not freeze with pass count");
    AST_COUNTED_DEC: assert property (
        ce && acq_w && (mode_q == wae_pkg::WAE_NAVG || mode_q == wae_pkg::WAE_NENV)
        && cnt_q > 16'h1 |=> cnt_q == $past(cnt_q) - 16'h1)
        else $error("counted mode did not decrement");
    AST_CENV_CNT: assert property (
        ce && acq_w && mode_q == wae_pkg::WAE_CENV && cnt_q != 16'hffff
        |=> cnt_q == $past(cnt_q) + 16'h1)
        else $error("envelope total did not advance");
    AST_PROMPT: assert property (
        ce && k_any |=> prompt_q == $past(key[`WAE_CMD_PASS]))
        else $error("pass prompt wrong after key");
    AST_NSTEP: assert property (
        nidx_q <= `WAE_NIDX_MAX && n_w >= `WAE_N_MIN)
        else $error("pass count out of range");

    COV_OVER:    cover property (ce && acq_w && mode_q == wae_pkg::WAE_CAVG && cnt_q == n16);
    COV_COUNTED: cover property (ce && acq_w && mode_q == wae_pkg::WAE_NENV && cnt_q == 16'h1);
    COV_SINGLE:  cover property (ce && acq_w && mode_q == wae_pkg::WAE_SINGLE && sproc_q[0]);
endmodule // wae_ctrl

// ### wae_acq_model.sv
`timescale 1ns/100ps

module wae_acq_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Request from the bench
    input  wire logic       acq_req,
    input  wire logic [2:0] acq_dly,
    // Digitizer side
    input  wire logic       acq_arm,
    output logic            acq_done
);
    // ==========================================================
    // Trigger wait and record capture
    logic       busy_q;
    logic [2:0] wait_q;

    // Record completes only while the digitizer is armed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q   <= 1'h0;
            wait_q   <= 3'h0;
            acq_done <= 1'h0;
        end else begin
            acq_done <= 1'h0;
            if (acq_req) begin
                busy_q <= 1'h1;
                wait_q <= acq_dly;
            end else if (busy_q && acq_arm) begin
                if (wait_q == 3'h0) begin
                    acq_done <= 1'h1;
                    busy_q   <= 1'h0;
                end else begin
                    wait_q <= wait_q - 3'h1;
                end
            end
        end
    end
endmodule // wae_acq_model

// ### waveform_average_envelope_control_test.sv
`timescale 1ns/100ps
`include "wae_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module waveform_average_envelope_control_test;
    // ==========================================================
    // Signals and model state
    logic               aclk = 0, aresetn = 0, ce = 1, acq_req = 0, acq_done;
    logic [2:0]         acq_dly = 0;
    logic [4:0]         awaddr = 0, araddr = 0;
    logic [31:0]        wdata = 0, rdata;
    logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp;
    logic               avg_en, envelope_en, acq_arm, frozen, over_flag, pass_prompt;
    logic [15:0]        readout;
    wae_pkg::wae_mode_t m = wae_pkg::WAE_NORMAL, pm = wae_pkg::WAE_NORMAL;
    int                 c = 0, n = 8, errors = 0, check_count = 0;
    bit                 ov = 0, pr = 0, rok = 0;
    logic [31:0]        d;
    logic [1:0]         r;
    int                 seq[$] = '{6, 0, 10, 8, 8, 4, 0, 9, 5, 8, 0, 0, 0, 2, 10, 1, 9, 4,
                                   1, 9, 5, 8, 1, 0, 1, 3, 1, 1, 3, 10, 2, 9, 4, 3, 9, 2,
                                   2, 9, 1, 3, 9, 0, 2, 9, 5, 8, 0, 0, 5, 8};

    wae_ctrl #(.STEP_CYC(16), .ADDR_W(5)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .acq_done(acq_done),
        .avg_en(avg_en), .envelope_en(envelope_en), .acq_arm(acq_arm), .frozen(frozen),
        .readout(readout), .over_flag(over_flag), .pass_prompt(pass_prompt));

    wae_acq_model i_acq (.aclk(aclk), .aresetn(aresetn), .acq_req(acq_req),
        .acq_dly(acq_dly), .acq_arm(acq_arm), .acq_done(acq_done));

    always #10 aclk = ~aclk;

    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit pa;
        bit pw;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        pa = 1;
        pw = 1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready) begin
                awvalid <= 1'h0;
                pa = 0;
            end
            if (pw && wready) begin
                wvalid <= 1'h0;
                pw = 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask

    // ==========================================================
    // Keys, acquisitions and state comparison
    task automatic key(input int k);
        wr(`WAE_REG_CMD, 32'h1 << k, r);
        pr = (k == 6);
        case (k)
            0: if (m == wae_pkg::WAE_CAVG) begin
                m = wae_pkg::WAE_NORMAL;
                rok = 0;
            end else begin
                m = wae_pkg::WAE_CAVG;
                c = 0;
                ov = 0;
                rok = 1;
            end
            1: if (m == wae_pkg::WAE_CENV) begin
                m = wae_pkg::WAE_NORMAL;
                rok = 0;
            end else begin
                m = wae_pkg::WAE_CENV;
                c = 0;
                rok = 1;
            end
            2, 3: begin
                m = (k == 2) ? wae_pkg::WAE_NAVG : wae_pkg::WAE_NENV;
                c = n;
                rok = 1;
            end
            4: m = wae_pkg::WAE_FROZEN;
            5: begin
                pm = m;
                m = wae_pkg::WAE_SINGLE;
                rok = rok && (pm == wae_pkg::WAE_CAVG || pm == wae_pkg::WAE_CENV);
            end
            default: ;
        endcase
    endtask

    task automatic acq();
        @(posedge aclk);
        acq_req <= 1'h1;
        acq_dly <= 3'($urandom % 5);
        @(posedge aclk);
        acq_req <= 1'h0;
        do @(posedge aclk); while (!acq_done);
        repeat (3) @(posedge aclk);
        case (m)
            wae_pkg::WAE_CAVG: if (c < n) c++; else ov = 1;
            wae_pkg::WAE_CENV: if (c < 65535) c++;
            wae_pkg::WAE_NAVG, wae_pkg::WAE_NENV: if (c == 1) begin
                m = wae_pkg::WAE_FROZEN;
                c = n;
            end else c--;
            wae_pkg::WAE_SINGLE: begin
                if (pm == wae_pkg::WAE_CENV || (pm == wae_pkg::WAE_CAVG && c < n)) c++;
                m = wae_pkg::WAE_FROZEN;
            end
            default: ;
        endcase
    endtask

    task automatic check();
        rd(`WAE_REG_STAT, d, r);
        `CHK("mode", 3'(m), d[2:0])
        `CHK("prompt", pr, pass_prompt)
        `CHK("frozen", m == wae_pkg::WAE_FROZEN, frozen)
        `CHK("arm", m != wae_pkg::WAE_FROZEN, acq_arm)
        if (m != wae_pkg::WAE_SINGLE) begin
            `CHK("avg", m == wae_pkg::WAE_CAVG || m == wae_pkg::WAE_NAVG, avg_en)
            `CHK("env", m == wae_pkg::WAE_CENV || m == wae_pkg::WAE_NENV, envelope_en)
        end
        if (rok && m != wae_pkg::WAE_SINGLE) begin
            rd(`WAE_REG_CNT, d, r);
            `CHK("count", 16'(c), d[15:0])
            `CHK("readout", 16'(c), readout)
        end
        if (m == wae_pkg::WAE_CAVG) `CHK("over", ov, over_flag)
    endtask

    task automatic pass_steps();
        int prev;
        int chg;
        prev = 0;
        chg = 0;
        wr(`WAE_REG_CTRL, 32'h1, r);
        for (int i = 0; i < 400 && !(chg >= 6 && prev == 0); i++) begin
            rd(`WAE_REG_STAT, d, r);
            `CHK("pass count", 9'(8 << d[7:5]), d[17:9])
            if (int'(d[7:5]) != prev) begin
                `CHK("pass step", 3'((prev + 1) % 6), d[7:5])
                prev = int'(d[7:5]);
                chg++;
            end
        end
        wr(`WAE_REG_CTRL, 32'h0, r);
        repeat (40) @(posedge aclk);
        rd(`WAE_REG_STAT, d, r);
        `CHK("pass kept", 3'h0, d[7:5])
        `CHK("steps", 6, chg)
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        #(20 * 30000);
        errors++;
        close_out();
    end

    initial begin
        void'($urandom(32'h49fed510));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`WAE_REG_CMD, d, r);
        `CHK("cmd read", 32'h0, d)
        rd(5'h10, d, r);
        `CHK("unmapped read", `WAE_RESP_SLVERR, r)
        wr(5'h14, $urandom, r);
        `CHK("unmapped write", `WAE_RESP_SLVERR, r)
        check();
        key(6);
        check();
        pass_steps();
        key(7);
        check();
        foreach (seq[i]) begin
            if (seq[i] == 9) repeat (1 + $urandom % 3) acq();
            else if (seq[i] == 10) repeat (n) acq();
            else if (seq[i] == 8) acq();
            else key(seq[i]);
            check();
        end
        // Clock enable low: a finished record must not count
        key(0);
        ce <= 1'h0;
        acq();
        ce <= 1'h1;
        c = 0;
        check();
        close_out();
    end
endmodule // waveform_average_envelope_control_test
